//--- tiop_top.sv
// Timed I/O port unit: five ports, six clock blocks, register port
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Contract
// - Ports of width 1, 4, 8, 16 and 32 bits, all sharing the low pins from pin 0 up.
// - All pins of one port share one direction.
// - Port drives pins or samples them, optionally waiting for a condition.
// - Every register access completes in one cycle.
// - Open collector: zero pulls low, one releases the pin.
// - Data passes through a shift register and a transfer register.
// - Each port has a 16-bit counter scheduling transfers.
// - Counter readable any time; transfers can wait for a counter value.
// - Counter captured as timestamp on each transfer.
// - Enabled link disables ports on its pins.
// - Enabled narrower port wins shared pins over wider ports.
// - A port always transfers its full width.
// - Six clock blocks; block 0 is the tile reference.
// - A clock block may take its clock from the 1-bit port.
// - Port-sourced clock may be divided.
// - Input strobe qualifies data; output strobe accompanies driven data.
// - After reset every port uses clock block 0.
// - Pin events go to the tile as event pulses.
module tiop_top (
   input wire logic clk,
   input wire logic reset_n,
   input tiop_pkg::tiop_req_t req,
   output logic [tiop_pkg::DW-1:0] rdata,
   input wire logic [tiop_pkg::DW-1:0] pin_in,
   output tiop_pkg::tiop_pins_t pins,
   input wire logic [tiop_pkg::NPORT-1:0] strobe_in,
   output logic [tiop_pkg::NPORT-1:0] strobe_out,
   output logic [tiop_pkg::NPORT-1:0] port_event
);
   import tiop_pkg::*;

   function automatic logic [DW-1:0] fmask(input int w);
      fmask = {DW{1'b1}} >> (DW - w);
   endfunction

   function automatic logic [5:0] lastchk(input int w);
      lastchk = 6'(DW / w - 1);
   endfunction

   function automatic logic is_reg(input tiop_addr_t x, input int k,
                                   input logic [2:0] r);
      is_reg = x.grp == G_PORT && x.port == 3'(k) && x.sel == r;
   endfunction

   function automatic logic cmatch(input tiop_cond_t c,
                                   input logic [DW-1:0] s,
                                   input logic [DW-1:0] v);
      case (c)
         TIOP_CND_EQ: cmatch = s == v;
         TIOP_CND_NE: cmatch = s != v;
         default: cmatch = 1'b1;
      endcase
   endfunction

   tiop_ctrl_t ctrl_q [NPORT];
   tiop_cb_t cb_q [NCB];
   logic link_q;
   logic [CW-1:0] cnt_q [NPORT];
   logic [CW-1:0] time_q [NPORT];
   logic [CW-1:0] ts_q [NPORT];
   logic [DW-1:0] cond_q [NPORT];
   logic [DW-1:0] xfer_q [NPORT];
   logic [DW-1:0] sr_q [NPORT];
   logic [DW-1:0] pval_q [NPORT];
   logic [5:0] nchk_q [NPORT];
   logic [NPORT-1:0] tarm_q, xvld_q, stb_q;
   logic [NPORT-1:0] tick, go, hit, last, mv;
   logic [DW-1:0] smp [NPORT];
   logic [DW-1:0] src [NPORT];
   logic [DW-1:0] sin [NPORT];
   logic [NCB-1:0] cbt;
   logic [DW-1:0] rd_d;
   tiop_addr_t a;
   tiop_pins_t pins_d;

   assign a = req.addr;

   // six clock blocks, block 0 fixed on reference
   for (genvar n = 0; n < NCB; n++) begin : g_cb
      tiop_clkblk u_cb (
         .clk(clk),
         .reset_n(reset_n),
         .cfg(cb_q[n]),
         .ref_tick(1'b1),
         .src_pin(pin_in[0]),
         .tick_q(cbt[n])
      );
   end

   always_comb begin
      for (int k = 0; k < NPORT; k++) begin
         tick[k] = (ctrl_q[k].cbsel < 3'(NCB)) ?
                   cbt[ctrl_q[k].cbsel] : cbt[0];
         // hold off until counter reaches time
         go[k] = tick[k] && ctrl_q[k].en &&
                 (!tarm_q[k] || cnt_q[k] == time_q[k]);
         smp[k] = pin_in & fmask(PW[k]);
         src[k] = (nchk_q[k] == 6'h00) ? xfer_q[k] : sr_q[k];
         sin[k] = (sr_q[k] >> PW[k]) | (smp[k] << (DW - PW[k]));
         last[k] = nchk_q[k] == lastchk(PW[k]);
         hit[k] = (!ctrl_q[k].strb || strobe_in[k]) &&
                  cmatch(ctrl_q[k].cond, smp[k], cond_q[k]);
         mv[k] = go[k] && (ctrl_q[k].dir ?
                 (xvld_q[k] || nchk_q[k] != 6'h00) : hit[k]);
      end
   end

   // Port configuration and wait condition
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int k = 0; k < NPORT; k++) begin
            ctrl_q[k] <= CTRL_RST;
            cond_q[k] <= '0;
         end
      end else begin
         for (int k = 0; k < NPORT; k++) begin
            if (mv[k] && !ctrl_q[k].dir)
               ctrl_q[k].cond <= TIOP_CND_NONE;
            if (req.we && is_reg(a, k, R_CTRL))
               ctrl_q[k] <= tiop_ctrl_t'(req.wdata[$bits(tiop_ctrl_t)-1:0]);
            if (req.we && is_reg(a, k, R_COND))
               cond_q[k] <= req.wdata;
         end
      end
   end

   // Clock block sources and link enable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int n = 0; n < NCB; n++)
            cb_q[n] <= CB_RST;
         link_q <= 1'b0;
      end else if (req.we && a.grp == G_GLB) begin
         for (int n = 1; n < NCB; n++) begin
            if (a.port == P_CB && a.sel == 3'(n))
               cb_q[n] <= tiop_cb_t'(req.wdata[$bits(tiop_cb_t)-1:0]);
         end
         if (a.port == P_LINK && a.sel == R_CTRL)
            link_q <= req.wdata[0];
      end
   end

   // Port counters
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int k = 0; k < NPORT; k++)
            cnt_q[k] <= '0;
      end else begin
         for (int k = 0; k < NPORT; k++) begin
            if (tick[k] && ctrl_q[k].en)
               cnt_q[k] <= cnt_q[k] + 16'h0001;
         end
      end
   end

   // Timed transfer arming
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tarm_q <= '0;
         for (int k = 0; k < NPORT; k++)
            time_q[k] <= '0;
      end else begin
         for (int k = 0; k < NPORT; k++) begin
            // Schedule gates the first chunk only, later chunks follow
            if (mv[k])
               tarm_q[k] <= 1'b0;
            if (req.we && is_reg(a, k, R_TIME)) begin
               time_q[k] <= req.wdata[CW-1:0];
               tarm_q[k] <= 1'b1;
            end
         end
      end
   end

   // Transfer register; a set beats a clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         xvld_q <= '0;
         for (int k = 0; k < NPORT; k++)
            xfer_q[k] <= '0;
      end else begin
         for (int k = 0; k < NPORT; k++) begin
            if (req.re && is_reg(a, k, R_DATA))
               xvld_q[k] <= 1'b0;
            if (mv[k] && ctrl_q[k].dir && nchk_q[k] == 6'h00)
               xvld_q[k] <= 1'b0;
            if (req.we && is_reg(a, k, R_DATA)) begin
               xfer_q[k] <= req.wdata;
               xvld_q[k] <= 1'b1;
            end
            // full word moves to transfer register
            if (mv[k] && !ctrl_q[k].dir && last[k]) begin
               xfer_q[k] <= sin[k];
               xvld_q[k] <= 1'b1;
            end
         end
      end
   end

   // Shift register, port value, timestamp, events, strobes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stb_q <= '0;
         strobe_out <= '0;
         port_event <= '0;
         for (int k = 0; k < NPORT; k++) begin
            sr_q[k] <= '0;
            pval_q[k] <= '0;
            nchk_q[k] <= '0;
            ts_q[k] <= '0;
         end
      end else begin
         strobe_out <= stb_q;
         for (int k = 0; k < NPORT; k++) begin
            stb_q[k] <= mv[k] && ctrl_q[k].dir;
            port_event[k] <= mv[k] && last[k];
            if (mv[k]) begin
               nchk_q[k] <= last[k] ? 6'h00 : nchk_q[k] + 6'h01;
               if (ctrl_q[k].dir) begin
                  pval_q[k] <= src[k] & fmask(PW[k]);
                  sr_q[k] <= src[k] >> PW[k];
               end else begin
                  sr_q[k] <= sin[k];
               end
               if (last[k])
                  ts_q[k] <= cnt_q[k];
            end
            // Reconfiguring a port drops a partly moved word
            if (req.we && is_reg(a, k, R_CTRL))
               nchk_q[k] <= 6'h00;
         end
      end
   end

   // Pin ownership and drive
   always_comb begin
      int own;
      own = -1;
      pins_d = '0;
      for (int j = 0; j < DW; j++) begin
         own = -1;
         for (int k = NPORT - 1; k >= 0; k--) begin
            if (ctrl_q[k].en && j < PW[k])
               own = k;
         end
         if (link_q && j >= LINK_LO)
            own = -1;
         if (own >= 0 && ctrl_q[own].dir) begin
            if (ctrl_q[own].oc) begin
               pins_d.oe[j] = !pval_q[own][j];
            end else begin
               pins_d.out[j] = pval_q[own][j];
               pins_d.oe[j] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         pins <= '0;
      else
         pins <= pins_d;
   end

   // Register read mux
   always_comb begin
      rd_d = '0;
      if (a.grp == G_PORT && a.port < 3'(NPORT)) begin
         case (a.sel)
            R_CTRL: rd_d = DW'(ctrl_q[a.port]);
            R_DATA: rd_d = xfer_q[a.port];
            R_TIME: rd_d = DW'(time_q[a.port]);
            R_CNT: rd_d = DW'(cnt_q[a.port]);
            R_TS: rd_d = DW'(ts_q[a.port]);
            R_COND: rd_d = cond_q[a.port];
            R_STAT: rd_d = DW'({tarm_q[a.port], xvld_q[a.port]});
            default: rd_d = '0;
         endcase
      end else if (a.grp == G_GLB && a.port == P_CB && a.sel < 3'(NCB)) begin
         rd_d = DW'(cb_q[a.sel]);
      end else if (a.grp == G_GLB && a.port == P_LINK && a.sel == R_CTRL) begin
         rd_d = DW'(link_q);
      end
   end

   // read data the cycle after, no wait
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         rdata <= '0;
      else
         rdata <= req.re ? rd_d : '0;
   end

   default clocking dck @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   AST_RD_CNT: assert property (req.re && is_reg(a, 4, R_CNT)
      |=> rdata == DW'($past(cnt_q[4])))
      else $error("counter read not answered next cycle");
   AST_CNT_STEP: assert property (tick[2] && ctrl_q[2].en
      |=> cnt_q[2] == $past(cnt_q[2]) + 16'h0001)
      else $error("port counter did not step");
   AST_TSTAMP: assert property (port_event[1]
      |-> ts_q[1] == $past(cnt_q[1]))
      else $error("timestamp not captured");
   AST_TIME_HOLD: assert property (tarm_q[4] && cnt_q[4] != time_q[4]
      |=> $stable(nchk_q[4]) && !port_event[4])
      else $error("transfer before scheduled time");
   AST_LINK: assert property (link_q
      |=> pins.oe[DW-1:LINK_LO] == '0)
      else $error("port drives link pins");
   AST_OC: assert property (ctrl_q[1].en && ctrl_q[1].oc
      && ctrl_q[1].dir && !ctrl_q[0].en
      |=> pins.out[3:0] == 4'h0 && pins.oe[3:0] == ~$past(pval_q[1][3:0]))
      else $error("open collector pin driven high");
   AST_DIR_IN: assert property (ctrl_q[4].en && !ctrl_q[4].dir
      && !ctrl_q[0].en && !ctrl_q[1].en && !ctrl_q[2].en && !ctrl_q[3].en
      |=> pins.oe == '0)
      else $error("input port drives pins");
   AST_NARROW: assert property (ctrl_q[0].en && ctrl_q[0].dir
      && !ctrl_q[0].oc |=> pins.oe[0] && pins.out[0] == $past(pval_q[0][0]))
      else $error("narrow port lost shared pin");
   AST_EVT: assert property (port_event[4] |-> $past(go[4]))
      else $error("event without port tick");
   AST_WAIT: assert property (go[0] && !ctrl_q[0].dir
      && ctrl_q[0].cond == TIOP_CND_EQ && smp[0] != cond_q[0]
      |=> $stable(nchk_q[0]) && !port_event[0])
      else $error("wait completed without match");
   AST_STROBE: assert property (mv[0] && ctrl_q[0].dir
      |=> ##1 strobe_out[0])
      else $error("output strobe missing");

   COV_OUT_DONE: cover property (port_event[0] && ctrl_q[0].dir);
   COV_WAIT_MET: cover property (mv[0] && ctrl_q[0].cond == TIOP_CND_EQ);
   COV_TIMED: cover property (tarm_q[4] && mv[4]);
   COV_PIN_CLK: cover property (ctrl_q[4].cbsel == 3'h1 && tick[4]);
endmodule

//--- tiop_pkg.sv
// Package: constants, register layout and types of the timed I/O port unit
package tiop_pkg;
   localparam int NPORT = 5;
   localparam int NCB = 6;
   localparam int DW = 32;
   localparam int CW = 16;
   localparam int AW = 8;
   localparam int PW [NPORT] = '{1, 4, 8, 16, 32};
   // Nominal tile reference rate; one tick per clk in this build
   localparam int REF_MHZ = 100;
   // Pins at and above this index are shared with the link
   localparam int LINK_LO = 16;
   localparam logic [1:0] G_PORT = 2'h0;
   localparam logic [1:0] G_GLB = 2'h1;
   localparam logic [2:0] R_CTRL = 3'h0;
   localparam logic [2:0] R_DATA = 3'h1;
   localparam logic [2:0] R_TIME = 3'h2;
   localparam logic [2:0] R_CNT = 3'h3;
   localparam logic [2:0] R_TS = 3'h4;
   localparam logic [2:0] R_COND = 3'h5;
   localparam logic [2:0] R_STAT = 3'h6;
   localparam logic [2:0] P_CB = 3'h0;
   localparam logic [2:0] P_LINK = 3'h1;
   typedef enum logic [1:0] {TIOP_CND_NONE, TIOP_CND_EQ, TIOP_CND_NE}
      tiop_cond_t;
   typedef struct packed {
      tiop_cond_t cond;
      logic [2:0] cbsel;
      logic strb;
      logic oc;
      logic dir;
      logic en;
   } tiop_ctrl_t;
   localparam tiop_ctrl_t CTRL_RST = '0;
   typedef struct packed {
      logic [7:0] div;
      logic src;
   } tiop_cb_t;
   localparam tiop_cb_t CB_RST = '0;
   typedef struct packed {
      logic [1:0] grp;
      logic [2:0] port;
      logic [2:0] sel;
   } tiop_addr_t;
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic we;
      logic re;
   } tiop_req_t;
   typedef struct packed {
      logic [DW-1:0] out;
      logic [DW-1:0] oe;
   } tiop_pins_t;
endpackage

//--- tiop_clkblk.sv
// Clock block: tick source select, optional divider
`timescale 1ns/10ps
module tiop_clkblk (
   input wire logic clk,
   input wire logic reset_n,
   input tiop_pkg::tiop_cb_t cfg,
   input wire logic ref_tick,
   input wire logic src_pin,
   output logic tick_q
);
   import tiop_pkg::*;
   logic pin_q;
   logic [7:0] div_q;
   logic base;
   logic hit;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         pin_q <= 1'b0;
      else
         pin_q <= src_pin;
   end

   assign base = cfg.src ? (src_pin && !pin_q) : ref_tick;
   assign hit = ({1'b0, div_q} + 9'h001) >= {1'b0, cfg.div};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         tick_q <= base && hit;
         if (base)
            div_q <= hit ? 8'h00 : div_q + 8'h01;
      end
   end

   AST_DIV_PASS: assert property (@(posedge clk) disable iff (!reset_n)
      !cfg.src && cfg.div == 8'h00 && ref_tick |=> tick_q)
      else $error("undivided reference tick lost");
   AST_SRC_EDGE: assert property (@(posedge clk) disable iff (!reset_n)
      cfg.src && !src_pin |=> !tick_q)
      else $error("tick without source pin edge");
endmodule

//--- tiop_ext.sv
// External hardware model standing at the pins of the port unit
`timescale 1ns/10ps
module tiop_ext (
   input wire logic clk,
   input wire logic reset_n,
   input tiop_pkg::tiop_pins_t pins,
   input wire logic [tiop_pkg::DW-1:0] ext_val,
   input wire logic [tiop_pkg::NPORT-1:0] ext_strb,
   input wire logic clk_run,
   output logic [tiop_pkg::DW-1:0] pin_in,
   output logic [tiop_pkg::NPORT-1:0] strobe_in
);
   import tiop_pkg::*;
   logic tog_q;
   // Application clock on pin 0 moves only while asked for
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tog_q <= 1'b0;
      end else if (clk_run) begin
         tog_q <= ~tog_q;
      end
   end
   assign pin_in = (pins.oe & pins.out)
      | (~pins.oe & (ext_val ^ {{(DW-1){1'b0}}, tog_q}));
   assign strobe_in = ext_strb;
endmodule

//--- tb_top.sv
// Self-checking testbench of the timed I/O port unit
`timescale 1ns/10ps
module tb_top;
   import tiop_pkg::*;
   logic clk;
   logic reset_n;
   tiop_req_t req;
   logic [DW-1:0] rdata;
   logic [DW-1:0] pin_in;
   tiop_pins_t pins;
   logic [NPORT-1:0] strobe_in;
   logic [NPORT-1:0] strobe_out;
   logic [NPORT-1:0] port_event;
   logic [DW-1:0] ext_val;
   logic [NPORT-1:0] ext_strb;
   logic clk_run;
   int error_cnt = 0;
   int samples_checked = 0;
   int seed = 32'hf26b;
   int cyc = 0;
   logic [DW-1:0] d, v, c1, c2;

   tiop_top tiop_top_i (.clk(clk), .reset_n(reset_n), .req(req),
      .rdata(rdata), .pin_in(pin_in), .pins(pins), .strobe_in(strobe_in),
      .strobe_out(strobe_out), .port_event(port_event));
   tiop_ext tiop_ext_i (.clk(clk), .reset_n(reset_n), .pins(pins),
      .ext_val(ext_val), .ext_strb(ext_strb), .clk_run(clk_run),
      .pin_in(pin_in), .strobe_in(strobe_in));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         error_cnt = error_cnt + 1;
         give_verdict();
      end
   end

   task give_verdict;
      $display("Counts: %0d checks, %0d mismatches", samples_checked,
         error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task cmp(input string what, input logic [DW-1:0] exp,
            input logic [DW-1:0] got);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task wr(input logic [AW-1:0] a, input logic [DW-1:0] w);
      @(posedge clk);
      req.we <= 1'b1;
      req.addr <= a;
      req.wdata <= w;
      @(posedge clk);
      req.we <= 1'b0;
   endtask

   task rd(input logic [AW-1:0] a, output logic [DW-1:0] r);
      @(posedge clk);
      req.re <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      req.re <= 1'b0;
      #1;
      r = rdata;
   endtask

   // Waits a bounded time for one pulse of event or output strobe
   task wait_hi(input int k, input bit ev, input int lim);
      bit seen;
      seen = 1'b0;
      for (int i = 0; i < lim && !seen; i++) begin
         @(posedge clk);
         #1;
         seen = ev ? (port_event[k] === 1'b1) : (strobe_out[k] === 1'b1);
      end
      cmp("pulse seen", 32'h1, {31'h0, seen});
   endtask

   task quiet(input int k, input bit ev, input int n);
      int hits;
      hits = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if ((ev ? port_event[k] : strobe_out[k]) === 1'b1) hits++;
      end
      cmp("quiet pulses", 32'h0, DW'(hits));
   endtask

   function automatic logic [DW-1:0] chunk(logic [DW-1:0] w, int wd, int i);
      logic [DW-1:0] m;
      m = (wd == DW) ? '1 : ((32'h1 << wd) - 32'h1);
      return (w >> (wd * i)) & m;
   endfunction

   // Sends one word and checks every chunk, LSB chunk first
   task out_word(input int k, input logic [DW-1:0] ctl,
                 input logic [DW-1:0] w);
      int wd;
      logic [DW-1:0] m, ch;
      wd = PW[k];
      m = chunk('1, wd, 0);
      wr(AW'(8 * k), ctl);
      wr(AW'(8 * k + 1), w);
      for (int i = 0; i < DW / wd; i++) begin
         wait_hi(k, 1'b0, 20);
         ch = chunk(w, wd, i);
         cmp("pins out", ctl[2] ? 32'h0 : ch, pins.out & m);
         cmp("pins oe", ctl[2] ? (~ch & m) : m, pins.oe & m);
      end
      wr(AW'(8 * k), 32'h0);
   endtask

   initial begin
      req = '0;
      reset_n = 1'b0;
      ext_val = '0;
      ext_strb = '0;
      clk_run = 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h00, v);
      cmp("ctrl reset", 32'h0, v);
      rd(8'h41, v);
      cmp("clock block reset", 32'h0, v);
      wr(8'h80, 32'h5a5a);
      rd(8'h80, v);
      cmp("unmapped", 32'h0, v);
      @(posedge clk);
      #1;
      cmp("rdata idle", 32'h0, rdata);
      $display("Test reset done");
      for (int k = 0; k < NPORT; k++) begin
         out_word(k, (k == 1) ? 32'h7 : 32'h3, $random(seed));
      end
      $display("Test widths done");
      v = $random(seed);
      @(posedge clk);
      ext_val <= v;
      wr(8'h20, 32'h1);
      wait_hi(4, 1'b1, 10);
      rd(8'h21, d);
      cmp("input word", v, d);
      wr(8'h20, 32'h9);
      repeat (3) @(posedge clk);
      quiet(4, 1'b1, 10);
      ext_strb[4] <= 1'b1;
      wait_hi(4, 1'b1, 10);
      ext_strb <= '0;
      wr(8'h20, 32'h0);
      ext_val <= '0;
      wr(8'h05, 32'h1);
      wr(8'h00, 32'h81);
      quiet(0, 1'b1, 40);
      @(posedge clk);
      ext_val <= 32'h1;
      wait_hi(0, 1'b1, 60);
      rd(8'h00, v);
      cmp("cond one-shot", 32'h1, v);
      wr(8'h00, 32'h0);
      $display("Test input done");
      wr(8'h20, 32'h3);
      rd(8'h23, c1);
      repeat (5) @(posedge clk);
      rd(8'h23, c2);
      cmp("count step", (c1 + 7) & 32'hffff, c2);
      wr(8'h22, (c2 + 40) & 32'hffff);
      d = $random(seed);
      wr(8'h21, d);
      quiet(4, 1'b0, 20);
      wait_hi(4, 1'b0, 40);
      cmp("timed out", d, pins.out);
      rd(8'h24, v);
      cmp("stamp", (c2 + 40) & 32'hffff, v);
      $display("Test timing done");
      wr(8'h48, 32'h1);
      d = $random(seed);
      wr(8'h21, d);
      wait_hi(4, 1'b0, 10);
      cmp("link oe", 32'h0000ffff, pins.oe);
      cmp("link low", d & 32'hffff, pins.out & 32'hffff);
      wr(8'h48, 32'h0);
      wr(8'h00, 32'h3);
      wr(8'h01, 32'hffffffff);
      d = $random(seed) & 32'hfffffffe;
      wr(8'h21, d);
      wait_hi(4, 1'b0, 10);
      cmp("shared out", {d[31:1], 1'b1}, pins.out);
      cmp("shared oe", 32'hffffffff, pins.oe);
      wr(8'h00, 32'h0);
      wr(8'h20, 32'h0);
      $display("Test sharing done");
      wr(8'h41, 32'h5);
      rd(8'h41, v);
      cmp("clock block cfg", 32'h5, v);
      wr(8'h20, 32'h11);
      rd(8'h23, c1);
      @(posedge clk);
      clk_run <= 1'b1;
      repeat (8) @(posedge clk);
      clk_run <= 1'b0;
      repeat (4) @(posedge clk);
      rd(8'h23, c2);
      cmp("divided ticks", (c1 + 2) & 32'hffff, c2);
      wr(8'h20, 32'h0);
      $display("Test clock block done");
      give_verdict();
   end
endmodule
